// ### ctm_counter.sv
/*
 * Compact 10-bit timer top: byte register port, paired-byte buffer,
 * counter, comparators, flags and the output pin.
 * Assumes a CPU-style master with one-cycle strobes and read data taken
 * the cycle after the read strobe.
 */
`timescale 1ns/1ps
// What this block does
// - Low compare byte write goes to buffer
// - High byte read latches low into buffer
// - Ten-bit up-counter, read-only to software
// - P compares bits 9-7; A all bits
// - Counter cleared by on-bit rise or a clear event
// - Counter clears on overflow or match
// - Pause bit holds counter, resume later
// - Clock select picks eight count sources
// - On-bit clear stops; set restarts from zero
// - On-bit rise reloads pin initial level
// - Period code times 128; zero gives 1024
// - Mode field: compare, PWM, timer
// - Compare mode: A match sets pin action
// - PWM pin function: inactive, active, waveform
// - Output control: initial level or polarity
// - Invert bit flips output pin, except in timer mode
// - Swap bit exchanges period and duty
// - Clear source selects A or P
// - Clear-on-A: no P flag, A-zero overflow
// - Compare pin changes only on A flag or on-bit rise
// - Duty at least period gives full active
// - PWM raises both flags; period clears
module ctm_counter (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       high_clk_en,
    input  wire logic       sub_clk_en,
    input  wire logic       external_count_input,
    output logic            timer_output_pin,
    output logic            match_a_flag,
    output logic            match_p_flag
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ********************************************************************
    // Register file
    // ********************************************************************
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [9:0] compare_a_value_q;
    logic [7:0] buf_q;
    logic [7:0] rdata_q;
    logic [1:0] flags_seen_q;

    wire wr_c0  = reg_wr && (reg_addr == ctm_pkg::CTM_REG_CTRL0);
    wire wr_c1  = reg_wr && (reg_addr == ctm_pkg::CTM_REG_CTRL1);
    wire wr_alo = reg_wr && (reg_addr == ctm_pkg::CTM_REG_CMPA_LO);
    wire wr_ahi = reg_wr && (reg_addr == ctm_pkg::CTM_REG_CMPA_HI);
    wire rd_dhi = reg_rd && (reg_addr == ctm_pkg::CTM_REG_CNT_HI);
    wire rd_ahi = reg_rd && (reg_addr == ctm_pkg::CTM_REG_CMPA_HI);
    wire rd_flg = reg_rd && (reg_addr == ctm_pkg::CTM_REG_FLAGS);

    wire       counter_pause      = ctrl0_q[ctm_pkg::CTM_C0_PAUSE];
    wire [2:0] count_clock_select = ctrl0_q[ctm_pkg::CTM_C0_CKS_LSB +: 3];
    wire       counter_on         = ctrl0_q[ctm_pkg::CTM_C0_ON];
    wire [2:0] period_compare_value = ctrl0_q[2:0];
    wire [1:0] mode_field         = ctrl1_q[ctm_pkg::CTM_C1_MODE_LSB +: 2];
    wire [1:0] pin_function       = ctrl1_q[ctm_pkg::CTM_C1_IO_LSB +: 2];
    wire       output_control     = ctrl1_q[ctm_pkg::CTM_C1_OC];
    wire       output_invert      = ctrl1_q[ctm_pkg::CTM_C1_POL];
    wire       period_duty_swap   = ctrl1_q[ctm_pkg::CTM_C1_DPX];
    wire       clear_source_select = ctrl1_q[ctm_pkg::CTM_C1_CCLR];

    logic [9:0] count_q;
    logic [9:0] count_d;
    logic       on_dly_q;
    logic       pin_q;
    logic       pin_d;
    logic       pulse_a_q;
    logic       pulse_p_q;

    wire on_rise = counter_on && !on_dly_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0_q           <= ctm_pkg::CTM_CTRL_RESET;
            ctrl1_q           <= ctm_pkg::CTM_CTRL_RESET;
            compare_a_value_q <= 10'h000;
            buf_q             <= 8'h00;
        end else begin
            if (wr_c0) begin
                ctrl0_q <= reg_wdata;
            end
            if (wr_c1) begin
                ctrl1_q <= reg_wdata;
            end
            if (wr_alo) begin
                buf_q <= reg_wdata;
            end else if (wr_ahi) begin
                compare_a_value_q <= {reg_wdata[1:0], buf_q};
            end else if (rd_dhi) begin
                buf_q <= count_q[7:0];
            end else if (rd_ahi) begin
                buf_q <= compare_a_value_q[7:0];
            end
        end
    end

    // ********************************************************************
    // Read path
    // ********************************************************************
    // Low-byte reads show the buffer; order is software's duty
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ctm_pkg::CTM_REG_CTRL0:   rd_mux = ctrl0_q;
            ctm_pkg::CTM_REG_CTRL1:   rd_mux = ctrl1_q;
            ctm_pkg::CTM_REG_CNT_LO:  rd_mux = buf_q;
            ctm_pkg::CTM_REG_CNT_HI:  rd_mux = {6'h00, count_q[9:8]};
            ctm_pkg::CTM_REG_CMPA_LO: rd_mux = buf_q;
            ctm_pkg::CTM_REG_CMPA_HI: rd_mux = {6'h00, compare_a_value_q[9:8]};
            ctm_pkg::CTM_REG_FLAGS:   rd_mux = {6'h00, flags_seen_q};
            default:                  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ********************************************************************
    // Count clock
    // ********************************************************************
    logic tick;
    ctm_clk_sel u_clk_sel (
        .clk                  (clk),
        .rst_b                (rst_b),
        .sel                  (count_clock_select),
        .high_clk_en          (high_clk_en),
        .sub_clk_en           (sub_clk_en),
        .external_count_input (external_count_input),
        .tick                 (tick)
    );

    // ********************************************************************
    // Comparators and clear
    // ********************************************************************
    wire is_pwm  = (mode_field == ctm_pkg::CTM_MODE_PWM);
    wire is_cmp  = (mode_field == ctm_pkg::CTM_MODE_CMP);
    wire run     = counter_on && !counter_pause && tick;
    // Match is seen while the counter sits one below the value the next count ends on
    wire [9:0] count_nx = count_q + 10'h001;
    wire p_hit = (period_compare_value != 3'h0)
                 && (count_nx == {period_compare_value, 7'h00});
    wire a_hit = (compare_a_value_q != 10'h000)
                 && (count_nx == compare_a_value_q);
    wire ovf   = (count_q == ctm_pkg::CTM_CNT_MAX);
    wire p_per = (period_compare_value == 3'h0) ? ovf : p_hit;
    wire a_per = (compare_a_value_q == 10'h000) ? ovf : a_hit;
    wire use_a_clr = is_pwm ? period_duty_swap : clear_source_select;
    wire clr_evt = use_a_clr ? a_per : p_per;
    wire raise_a = run && a_hit;
    wire raise_p = run && p_hit && (is_pwm || !clear_source_select);

    always_comb begin
        count_d = count_q;
        if (on_rise) begin
            count_d = 10'h000;
        end else if (run) begin
            count_d = clr_evt ? 10'h000 : count_nx;
        end
    end

    // ********************************************************************
    // Output pin
    // ********************************************************************
    // PWM duty compare is on the live count; duty >= period stays active
    // Code 000 stands for 1024, and so does a zero compare value used as period, hence bit 10
    wire [10:0] duty_v = period_duty_swap ? {(period_compare_value == 3'h0),
                                             period_compare_value, 7'h00}
                                          : {1'b0, compare_a_value_q};
    wire [10:0] per_v = period_duty_swap ? {(compare_a_value_q == 10'h000),
                                            compare_a_value_q}
                                         : {(period_compare_value == 3'h0),
                                            period_compare_value, 7'h00};
    wire duty_full   = (duty_v >= per_v);
    wire duty_active = ({1'b0, count_q} < duty_v) || duty_full;
    logic pwm_lvl;
    always_comb begin
        case (pin_function)
            ctm_pkg::CTM_IO_NONE: pwm_lvl = !output_control;
            ctm_pkg::CTM_IO_LOW:  pwm_lvl = output_control;
            ctm_pkg::CTM_IO_HIGH: pwm_lvl = duty_active ? output_control
                                                        : !output_control;
            default:              pwm_lvl = pin_q;
        endcase
    end

    always_comb begin
        pin_d = pin_q;
        if (on_rise && (is_cmp || is_pwm)) begin
            pin_d = output_control;
        end else if (is_pwm) begin
            pin_d = counter_on ? pwm_lvl : pin_q;
        end else if (is_cmp && raise_a) begin
            case (pin_function)
                ctm_pkg::CTM_IO_LOW:  pin_d = 1'b0;
                ctm_pkg::CTM_IO_HIGH: pin_d = 1'b1;
                ctm_pkg::CTM_IO_TOG:  pin_d = !pin_q;
                default:              pin_d = pin_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q   <= 10'h000;
            on_dly_q  <= 1'b0;
            pin_q     <= 1'b0;
            pulse_a_q <= 1'b0;
            pulse_p_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            on_dly_q  <= counter_on;
            pin_q     <= pin_d;
            pulse_a_q <= raise_a;
            pulse_p_q <= raise_p;
        end
    end

    // Sticky copy for software; set wins over the read clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_seen_q <= 2'h0;
        end else begin
            flags_seen_q <= ({raise_p, raise_a}) | (rd_flg ? 2'h0 : flags_seen_q);
        end
    end

    // Timer mode leaves the pin at a plain low; invert is ignored there
    assign timer_output_pin = (mode_field == ctm_pkg::CTM_MODE_TMR) ? 1'b0
                              : (pin_q ^ output_invert);
    assign match_a_flag = pulse_a_q;
    assign match_p_flag = pulse_p_q;

    // ********************************************************************
    // Sequences
    // ********************************************************************
    sequence s_lo_then_hi;
        wr_alo ##1 wr_ahi;
    endsequence

    sequence s_cmp_toggle;
        is_cmp && raise_a && !on_rise && (pin_function == ctm_pkg::CTM_IO_TOG);
    endsequence

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_on_rise_clears: assert property (
        on_rise |=> (count_q == 10'h000))
        else $error("on rise did not clear");

    a_pause_holds: assert property (
        (counter_pause && !on_rise) |=> $stable(count_q))
        else $error("pause moved counter");

    a_off_holds: assert property (
        !counter_on |=> $stable(count_q))
        else $error("off moved counter");

    a_no_p_flag: assert property (
        (!is_pwm && clear_source_select) |=> !match_p_flag)
        else $error("P flag with A clear");

    a_pin_initial: assert property (
        (on_rise && (is_cmp || is_pwm)) |=> (pin_q == $past(output_control)))
        else $error("pin not reset");

    a_cmp_pin_only_a: assert property (
        (is_cmp && !on_rise && !raise_a) |=> $stable(pin_q))
        else $error("pin moved w/o A");

    a_flag_pulse: assert property (
        (match_a_flag && !tick) |=> !match_a_flag)
        else $error("A flag not a pulse");

    a_p_flag_pulse: assert property (
        (match_p_flag && !tick) |=> !match_p_flag)
        else $error("P flag not a pulse");

    a_buf_write: assert property (
        s_lo_then_hi |=> (compare_a_value_q[7:0] == $past(reg_wdata, 2)))
        else $error("buffer lost");

    a_hi_read_latch: assert property (
        rd_ahi |=> (buf_q == $past(compare_a_value_q[7:0])))
        else $error("read latch");

    a_cnt_read_latch: assert property (
        rd_dhi |=> (buf_q == $past(count_q[7:0])))
        else $error("count read latch");

    // Mode only changes while stopped, so the match mode still holds next cycle
    a_invert_pin: assert property (
        (is_cmp && raise_a && !on_rise && (pin_function == ctm_pkg::CTM_IO_HIGH))
        |=> (timer_output_pin == !output_invert))
        else $error("invert");

    a_cmp_toggle: assert property (
        s_cmp_toggle |=> (pin_q != $past(pin_q)))
        else $error("toggle missed");

    a_clr_on_a: assert property (
        (!is_pwm && clear_source_select && raise_a) |=> (count_q == 10'h000))
        else $error("A match did not clear");

    a_clr_on_p: assert property (
        (!is_pwm && !clear_source_select && raise_p) |=> (count_q == 10'h000))
        else $error("P match did not clear");

    // A tick that neither clears nor restarts moves the count by one
    a_count_step: assert property (
        (run && !on_rise && !clr_evt) |=> (count_q == $past(count_q) + 10'h001))
        else $error("count step");

    // Full duty keeps the active level across the period wrap
    a_full_duty: assert property (
        (is_pwm && counter_on && !on_rise && duty_full
         && (pin_function == ctm_pkg::CTM_IO_HIGH))
        |=> (pin_q == $past(output_control)))
        else $error("full duty broke");
endmodule

// ### ctm_pkg.sv
/*
 * Package for the compact 10-bit timer: register indices, field positions,
 * reset values, mode and clock-select codes.
 * Assumes a byte-wide register port with one-cycle strobes.
 */
package ctm_pkg;
    // ********************************************************************
    // Register indices on the byte port
    // ********************************************************************
    localparam logic [2:0] CTM_REG_CTRL0  = 3'h0;
    localparam logic [2:0] CTM_REG_CTRL1  = 3'h1;
    localparam logic [2:0] CTM_REG_CNT_LO = 3'h2;
    localparam logic [2:0] CTM_REG_CNT_HI = 3'h3;
    localparam logic [2:0] CTM_REG_CMPA_LO = 3'h4;
    localparam logic [2:0] CTM_REG_CMPA_HI = 3'h5;
    localparam logic [2:0] CTM_REG_FLAGS  = 3'h6;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int CTM_C0_PAUSE   = 7;
    localparam int CTM_C0_CKS_LSB = 4;
    localparam int CTM_C0_ON      = 3;
    localparam int CTM_C1_MODE_LSB = 6;
    localparam int CTM_C1_IO_LSB  = 4;
    localparam int CTM_C1_OC      = 3;
    localparam int CTM_C1_POL     = 2;
    localparam int CTM_C1_DPX     = 1;
    localparam int CTM_C1_CCLR    = 0;

    localparam logic [7:0] CTM_CTRL_RESET = 8'h00;
    localparam logic [9:0] CTM_CNT_MAX    = 10'h3FF;

    // ********************************************************************
    // Codes
    // ********************************************************************
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR = 2'h3;

    localparam logic [1:0] CTM_IO_NONE = 2'h0;
    localparam logic [1:0] CTM_IO_LOW  = 2'h1;
    localparam logic [1:0] CTM_IO_HIGH = 2'h2;
    localparam logic [1:0] CTM_IO_TOG  = 2'h3;

    localparam logic [2:0] CTM_CKS_SYS4  = 3'h0;
    localparam logic [2:0] CTM_CKS_SYS   = 3'h1;
    localparam logic [2:0] CTM_CKS_H16   = 3'h2;
    localparam logic [2:0] CTM_CKS_H64   = 3'h3;
    localparam logic [2:0] CTM_CKS_SUB0  = 3'h4;
    localparam logic [2:0] CTM_CKS_SUB1  = 3'h5;
    localparam logic [2:0] CTM_CKS_EXTR  = 3'h6;
    localparam logic [2:0] CTM_CKS_EXTF  = 3'h7;

    localparam int CTM_DIV_SYS = 4;
    localparam int CTM_DIV_H16 = 16;
    localparam int CTM_DIV_H64 = 64;
endpackage

// ### ctm_clk_sel.sv
/*
 * Count clock selection: turns the chosen source into a one-cycle count
 * enable on clk.
 * Assumes high and sub clocks arrive as enable pulses on clk, and the
 * external count pin is asynchronous.
 */
`timescale 1ns/1ps
module ctm_clk_sel (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] sel,
    input  wire logic       high_clk_en,
    input  wire logic       sub_clk_en,
    input  wire logic       external_count_input,
    output logic            tick
);
    // ********************************************************************
    // Dividers and pin edge detection
    // ********************************************************************
    logic [5:0] sys_div_q;
    logic [5:0] h_div_q;
    logic       ext_s1_q;
    logic       ext_s2_q;
    logic       ext_s3_q;
    wire        sys4_en = (sys_div_q[1:0] == 2'h3);
    wire        h16_en  = high_clk_en && (h_div_q[3:0] == 4'hF);
    wire        h64_en  = high_clk_en && (h_div_q == 6'h3F);
    wire        ext_rise = ext_s2_q && !ext_s3_q;
    wire        ext_fall = !ext_s2_q && ext_s3_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_div_q <= 6'h00;
            h_div_q   <= 6'h00;
            ext_s1_q  <= 1'b0;
            ext_s2_q  <= 1'b0;
            ext_s3_q  <= 1'b0;
        end else begin
            sys_div_q <= sys_div_q + 6'h01;
            if (high_clk_en) begin
                h_div_q <= h_div_q + 6'h01;
            end
            // Second stage only feeds the edge detector, never the first
            ext_s1_q <= external_count_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    always_comb begin
        case (sel)
            ctm_pkg::CTM_CKS_SYS4: tick = sys4_en;
            ctm_pkg::CTM_CKS_SYS:  tick = 1'b1;
            ctm_pkg::CTM_CKS_H16:  tick = h16_en;
            ctm_pkg::CTM_CKS_H64:  tick = h64_en;
            ctm_pkg::CTM_CKS_SUB0: tick = sub_clk_en;
            ctm_pkg::CTM_CKS_SUB1: tick = sub_clk_en;
            ctm_pkg::CTM_CKS_EXTR: tick = ext_rise;
            default:               tick = ext_fall;
        endcase
    end
endmodule

// ### ctm_cpu_model.sv
/*
 * CPU side model of the compact timer register port: byte reads, byte
 * writes and the ordered paired-byte and reconfiguration sequences.
 * Assumes one clock and a slave that never stalls the master.
 */
`timescale 1ns/1ps
module ctm_cpu_model (
    input  wire logic       clk,
    output logic [2:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic wr_cmpa(input logic [9:0] v);
        wr(3'h4, v[7:0]);
        wr(3'h5, {6'h00, v[9:8]});
    endtask

    task automatic rd_pair(input logic [2:0] hi, output logic [9:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(hi, h);
        rd(hi - 3'h1, l);
        v = {h[1:0], l};
    endtask

    // Mode and pin function only change while stopped
    task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h0, c0);
    endtask
endmodule

// ### ctm_counter_tb.sv
/*
 * Self-checking bench for the compact timer: registers, byte pairs,
 * compare, timer and PWM modes, pause and every count source.
 * Assumes the 200 MHz clock and the CPU model on the register port.
 */
`timescale 1ns/1ps
module ctm_counter_tb;
    logic       clk;
    logic       rst_b;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       high_clk_en;
    logic       sub_clk_en;
    logic       external_count_input;
    logic       timer_output_pin;
    logic       match_a_flag;
    logic       match_p_flag;
    logic [2:0] phase_q;
    int         mismatches;
    int         checks_done;
    int         p_seen;

    ctm_counter dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_clk_en(high_clk_en),
        .sub_clk_en(sub_clk_en), .external_count_input(external_count_input),
        .timer_output_pin(timer_output_pin), .match_a_flag(match_a_flag),
        .match_p_flag(match_p_flag));
    ctm_cpu_model cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ********************************************************************
    // Clock and count sources
    // ********************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // High clock every 2nd cycle, sub every 4th, pin period 8 cycles
    always @(posedge clk) begin
        phase_q <= phase_q + 3'h1;
        high_clk_en <= phase_q[0];
        sub_clk_en <= (phase_q[1:0] == 2'h0);
        external_count_input <= phase_q[2];
        if (match_p_flag === 1'b1) p_seen <= p_seen + 1;
    end

    // ********************************************************************
    // Compare, wait and close
    // ********************************************************************
    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Cycles up to the next flag pulse, or lim when none comes
    task automatic gap(input logic sel_p, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (((sel_p ? match_p_flag : match_a_flag) !== 1'b1) && n < lim);
    endtask

    task automatic hi_count(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge clk);
            #1;
            if (timer_output_pin === 1'b1) n++;
        end
    endtask

    task automatic pin_after(input int cyc, input logic e);
        repeat (cyc) @(posedge clk);
        #1;
        chkv({15'h0000, timer_output_pin}, {15'h0000, e});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_regs;
        logic [7:0] v;
        logic [9:0] w;
        cpu.wr(3'h2, 8'hFF);
        cpu.wr(3'h3, 8'hFF);
        cpu.wr(3'h7, 8'hFF);
        for (int a = 0; a < 8; a++) begin
            cpu.rd(a[2:0], v);
            chkv({8'h00, v}, 16'h0000);
        end
        cpu.wr(3'h0, 8'hE7);
        cpu.rd(3'h0, v);
        chkv({8'h00, v}, 16'h00E7);
        cpu.wr(3'h1, 8'h3B);
        cpu.rd(3'h1, v);
        chkv({8'h00, v}, 16'h003B);
        cpu.wr(3'h0, 8'h00);
        cpu.wr(3'h4, 8'hA5);
        cpu.rd(3'h5, v);
        chkv({8'h00, v}, 16'h0000);
        cpu.rd(3'h4, v);
        chkv({8'h00, v}, 16'h0000);
        cpu.wr_cmpa(10'h23C);
        cpu.rd_pair(3'h5, w);
        chkv({6'h00, w}, 16'h023C);
        cpu.rd(3'h5, v);
        cpu.rd(3'h2, v);
        chkv({8'h00, v}, 16'h003C);
        $display("test regs done");
    endtask

    task automatic t_cmp;
        logic [7:0] c1s [3];
        int n;
        int ps;
        c1s = '{8'h18, 8'h20, 8'h08};
        cpu.wr_cmpa(10'd50);
        cpu.cfg(8'h19, 8'h38);
        pin_after(3, 1'b1);
        gap(1'b0, 300, n);
        pin_after(2, 1'b0);
        cpu.cfg(8'h19, 8'h38);
        pin_after(3, 1'b1);
        gap(1'b1, 300, n);
        gap(1'b1, 300, n);
        chkn(n, 128);
        gap(1'b0, 300, n);
        chkn(n, 50);
        for (int i = 0; i < 3; i++) begin
            cpu.cfg(8'h19, c1s[i]);
            gap(1'b0, 300, n);
            pin_after(2, i != 0);
        end
        cpu.wr_cmpa(10'd200);
        cpu.cfg(8'h19, 8'h25);
        pin_after(3, 1'b1);
        ps = p_seen;
        gap(1'b0, 400, n);
        pin_after(2, 1'b0);
        gap(1'b0, 400, n);
        chkn(n, 198);
        chkn(p_seen - ps, 0);
        cpu.wr_cmpa(10'd0);
        cpu.cfg(8'h19, 8'h25);
        gap(1'b0, 1100, n);
        chkn(n, 1100);
        cpu.wr_cmpa(10'd50);
        cpu.cfg(8'h19, 8'hF8);
        gap(1'b0, 300, n);
        gap(1'b0, 300, n);
        chkn(n, 128);
        pin_after(1, 1'b0);
        $display("test compare done");
    endtask

    task automatic t_pause;
        logic [9:0] v1;
        logic [9:0] v2;
        cpu.cfg(8'h18, 8'h00);
        repeat (20) @(posedge clk);
        cpu.wr(3'h0, 8'h98);
        cpu.rd_pair(3'h3, v1);
        repeat (30) @(posedge clk);
        cpu.rd_pair(3'h3, v2);
        chkv({6'h00, v2}, {6'h00, v1});
        cpu.wr(3'h0, 8'h18);
        repeat (20) @(posedge clk);
        cpu.rd_pair(3'h3, v2);
        chkv({15'h0000, v2 > v1 + 10'd19 && v2 < v1 + 10'd40}, 16'h0001);
        cpu.wr(3'h0, 8'h10);
        cpu.rd_pair(3'h3, v1);
        repeat (30) @(posedge clk);
        cpu.rd_pair(3'h3, v2);
        chkv({6'h00, v2}, {6'h00, v1});
        cpu.wr(3'h0, 8'h18);
        cpu.rd_pair(3'h3, v2);
        chkv({15'h0000, v2 < 10'd12 && v1 > 10'd40}, 16'h0001);
        $display("test pause done");
    endtask

    task automatic pwm(input logic [7:0] c1, input logic [9:0] a, input logic sel_p,
                       input int len, input int exp);
        int n;
        cpu.wr_cmpa(a);
        cpu.cfg(8'h19, c1);
        gap(sel_p, 400, n);
        hi_count(len, n);
        chkn(n, exp);
    endtask

    task automatic t_pwm;
        int n;
        pwm(8'hA8, 10'd32, 1'b1, 128, 32);
        pwm(8'hA0, 10'd32, 1'b1, 128, 96);
        pwm(8'hAC, 10'd32, 1'b1, 128, 96);
        pwm(8'hA8, 10'd200, 1'b1, 128, 128);
        pwm(8'h88, 10'd32, 1'b1, 128, 0);
        pwm(8'h98, 10'd32, 1'b1, 128, 128);
        pwm(8'hAA, 10'd300, 1'b0, 300, 128);
        gap(1'b1, 400, n);
        chkn(n < 301, 1);
        cpu.wr_cmpa(10'd300);
        cpu.cfg(8'h18, 8'hAA);
        gap(1'b0, 400, n);
        hi_count(300, n);
        chkn(n, 300);
        $display("test pwm done");
    endtask

    // Cycles per count: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall
    task automatic t_clk;
        int dv [8];
        int n;
        dv = '{4, 1, 32, 128, 4, 4, 8, 8};
        for (int i = 0; i < 8; i++) begin
            cpu.cfg({1'b0, i[2:0], 1'b1, 3'h1}, 8'h00);
            gap(1'b1, 256 * dv[i] + 100, n);
            gap(1'b1, 256 * dv[i] + 100, n);
            chkn(n, 128 * dv[i]);
        end
        $display("test clock select done");
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial begin
        rst_b = 1'b0;
        phase_q = 3'h0;
        high_clk_en = 1'b0;
        sub_clk_en = 1'b0;
        external_count_input = 1'b0;
        mismatches = 0;
        checks_done = 0;
        p_seen = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_cmp();
        t_pause();
        t_pwm();
        t_clk();
        test_done();
    end

    // Whole run is about 60000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule
